// >>> src/acs_defines.vh
// How it works
// - mux routes channel from address bits
// - sequencer bits 11 start ascending sequence
// - first transfer after programming converts channel 0
// - writes during sequence use sequencer bits 10
// - other sequencer codes end the sequence
// - after final channel wrap to channel 0
// - word is zeros, address, twelve-bit result
// - shorter results padded with trailing zeros
// - first twelve bits load control when write set
// - power bits 11 keep device powered
// - write bit low keeps power bits
// - chip select fall starts conversion, holds
// - sixteen clocks, track on 14th fall
// - power bits 10 give full shutdown
// - wake from shutdown on chip select rise
// - hold during shutdown, waking write tracks on 14th fall
// - range bit picks single or double span
// - upper sequencer bit 0 uses written address
// - early chip select rise aborts, no update
// - power bits 01 give auto shutdown
`ifndef ACS_DEFINES_VH
`define ACS_DEFINES_VH
`define ACS_CTRL_BITS     12
`define ACS_WORD_BITS     16
`define ACS_BIT_WRITE     11
`define ACS_BIT_SEQ_HI    10
`define ACS_BIT_SEQ_LO    3
`define ACS_BIT_ADDR_HI   7
`define ACS_BIT_ADDR_LO   6
`define ACS_BIT_PM_HI     5
`define ACS_BIT_PM_LO     4
`define ACS_BIT_RANGE     1
`define ACS_TRACK_EDGE    14
`define ACS_DONE_EDGE     16
`define ACS_CTRL_RESET    12'h000
`define ACS_PM_NORMAL     2'h3
`define ACS_PM_FULL_SD    2'h2
`define ACS_PM_AUTO_SD    2'h1
`define ACS_RES_12        2'h0
`define ACS_RES_10        2'h1
`define ACS_RES_8         2'h2
`define ACS_FIFO_DEPTH    16
`define ACS_FIFO_AW       4
`define ACS_WAKE_NS       1000
`define ACS_CLK_NS        100
`endif

// >>> src/acs_sync.v
`timescale 1ns/1ns
`default_nettype none
module acs_sync (
  input  wire core_clk,
  input  wire reset_n,
  input  wire din,
  output reg  dout
);
  reg stage;
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      stage <= 1'b0;
      dout  <= 1'b0;
    end else begin
      stage <= din;
      dout  <= stage;
    end
  end
endmodule
`default_nettype wire

// >>> src/acs_fifo.v
`timescale 1ns/1ns
`default_nettype none
module acs_fifo #(
  parameter WIDTH = 16,
  parameter DEPTH = 16,
  parameter AW    = 4
) (
  input  wire             core_clk,
  input  wire             reset_n,
  input  wire             in_valid,
  output wire             in_ready,
  input  wire [WIDTH-1:0] in_data,
  output wire             out_valid,
  input  wire             out_ready,
  output reg  [WIDTH-1:0] out_data
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW:0]      wr_ptr;
  reg [AW:0]      rd_ptr;
  reg             out_full;
  wire            empty = (wr_ptr == rd_ptr);
  wire            full  = (wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
  wire            pop   = !empty && (!out_full || out_ready);
  assign in_ready  = !full;
  assign out_valid = out_full;
  always @(posedge core_clk) begin
    if (in_valid && !full) begin
      mem[wr_ptr[AW-1:0]] <= in_data;
    end
  end
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      wr_ptr   <= {(AW+1){1'b0}};
      rd_ptr   <= {(AW+1){1'b0}};
      out_full <= 1'b0;
      out_data <= {WIDTH{1'b0}};
    end else begin
      if (in_valid && !full) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        out_data <= mem[rd_ptr[AW-1:0]];
        rd_ptr   <= rd_ptr + 1'b1;
        out_full <= 1'b1;
      end else if (out_ready) begin
        out_full <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// >>> src/acs_core.v
`timescale 1ns/1ns
`default_nettype none
`include "acs_defines.vh"
module acs_core #(
  parameter RES_MODE = 0
) (
  input  wire        core_clk,
  input  wire        reset_n,
  input  wire        cs_n,
  input  wire        sclk,
  input  wire        sdi,
  output reg         sdo,
  output reg         sdo_oe,
  input  wire [11:0] conv_result,
  output reg  [1:0]  mux_chan,
  output reg         track_hold,
  output reg         powered,
  output reg         range_double,
  output reg         conv_start,
  output wire        word_valid,
  input  wire        word_ready,
  output wire [15:0] word_data,
  output reg  [11:0] ctrl_reg,
  output reg         seq_active
);
  localparam ST_IDLE = 2'h0;
  localparam ST_XFER = 2'h1;
  localparam ST_DONE = 2'h2;
  localparam integer WAKE_NUM = (`ACS_WAKE_NS + `ACS_CLK_NS - 1) / `ACS_CLK_NS;
  localparam [6:0]   WAKE_CYC = WAKE_NUM[6:0];
  //////////////////////////////////////////////////////////////////////////////
  // every pin passes two flip-flops before the edge logic reads it
  wire [2:0] pin_raw = {cs_n, sclk, sdi};
  wire [2:0] pin_sync;
  genvar     gi;
  generate
    for (gi = 0; gi < 3; gi = gi + 1) begin : g_sync
      acs_sync u_sync (
        .core_clk (core_clk),
        .reset_n  (reset_n),
        .din      (pin_raw[gi]),
        .dout     (pin_sync[gi])
      );
    end
  endgenerate
  wire cs_s   = pin_sync[2];
  wire sclk_s = pin_sync[1];
  wire sdi_s  = pin_sync[0];
  reg  cs_d;
  reg  sclk_d;
  reg  init_done;
  wire cs_fall   = init_done && cs_d && !cs_s;
  wire cs_rise   = init_done && !cs_d && cs_s;
  wire sclk_fall = init_done && sclk_d && !sclk_s;
  wire sclk_rise = init_done && !sclk_d && sclk_s;
  //////////////////////////////////////////////////////////////////////////////
  function [11:0] pad_result;
    input [11:0] r;
    input [1:0]  mode;
    begin
      if (mode == `ACS_RES_10) begin
        pad_result = {r[9:0], 2'h0};
      end else if (mode == `ACS_RES_8) begin
        pad_result = {r[7:0], 4'h0};
      end else begin
        pad_result = r;
      end
    end
  endfunction
  //////////////////////////////////////////////////////////////////////////////
  reg [1:0]  state;
  reg [4:0]  fall_cnt;
  reg [11:0] shift_in;
  reg [15:0] shift_out;
  reg [1:0]  seq_chan;
  reg [1:0]  conv_chan;
  reg        wake_pend;
  reg [6:0]  wake_cnt;
  reg        word_push;
  reg [15:0] word_buf;
  wire       fifo_in_ready;
  wire [1:0] pm_now    = {ctrl_reg[`ACS_BIT_PM_HI], ctrl_reg[`ACS_BIT_PM_LO]};
  wire [1:0] final_ch  = {ctrl_reg[`ACS_BIT_ADDR_HI], ctrl_reg[`ACS_BIT_ADDR_LO]};
  wire [1:0] new_seq   = {shift_in[`ACS_BIT_SEQ_HI], shift_in[`ACS_BIT_SEQ_LO]};
  wire [1:0] new_addr  = {shift_in[`ACS_BIT_ADDR_HI], shift_in[`ACS_BIT_ADDR_LO]};
  wire [1:0] new_pm    = {shift_in[`ACS_BIT_PM_HI], shift_in[`ACS_BIT_PM_LO]};
  // channel picked at the falling edge of chip select
  wire [1:0] next_chan = seq_active ? seq_chan : final_ch;
  //////////////////////////////////////////////////////////////////////////////
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      cs_d         <= 1'b1;
      sclk_d       <= 1'b0;
      init_done    <= 1'b0;
      state        <= ST_IDLE;
      fall_cnt     <= 5'h00;
      shift_in     <= 12'h000;
      shift_out    <= 16'h0000;
      ctrl_reg     <= `ACS_CTRL_RESET;
      seq_active   <= 1'b0;
      seq_chan     <= 2'h0;
      conv_chan    <= 2'h0;
      mux_chan     <= 2'h0;
      track_hold   <= 1'b0;
      powered      <= 1'b1;
      range_double <= 1'b1;
      conv_start   <= 1'b0;
      sdo          <= 1'b0;
      sdo_oe       <= 1'b0;
      wake_pend    <= 1'b0;
      wake_cnt     <= 7'h00;
      word_push    <= 1'b0;
      word_buf     <= 16'h0000;
    end else begin
      cs_d       <= cs_s;
      sclk_d     <= sclk_s;
      init_done  <= 1'b1;
      conv_start <= 1'b0;
      if (word_push && fifo_in_ready) begin
        word_push <= 1'b0;
      end
      if (wake_pend) begin
        if (wake_cnt == WAKE_CYC) begin
          wake_pend <= 1'b0;
          powered   <= 1'b1;
        end else begin
          wake_cnt <= wake_cnt + 7'h01;
        end
      end
      case (state)
        ST_IDLE: begin
          // a chip select fall is ignored while an output word is pending
          if (cs_fall && !word_push) begin
            state      <= ST_XFER;
            fall_cnt   <= 5'h00;
            track_hold <= 1'b1;
            conv_start <= 1'b1;
            conv_chan  <= next_chan;
            mux_chan   <= next_chan;
            sdo_oe     <= 1'b1;
            sdo        <= 1'b0;
            if (pm_now == `ACS_PM_AUTO_SD) begin
              powered <= 1'b1;
            end
            if (seq_active) begin
              seq_chan <= (seq_chan == final_ch) ? 2'h0 : seq_chan + 2'h1;
            end
          end
        end
        ST_XFER: begin
          if (cs_rise) begin
            state  <= ST_IDLE;
            sdo_oe <= 1'b0;
            if (pm_now != `ACS_PM_FULL_SD) begin
              track_hold <= 1'b0;
            end
          end else if (sclk_rise && fall_cnt <= `ACS_CTRL_BITS) begin
            shift_in <= {shift_in[10:0], sdi_s};
          end else if (sclk_fall) begin
            fall_cnt <= fall_cnt + 5'h01;
            if (fall_cnt == 5'h00) begin
              // address bits leave on the 2nd fall, result follows
              shift_out <= {conv_chan, pad_result(conv_result, RES_MODE[1:0]),
                            2'h0};
              sdo       <= 1'b0;
            end else begin
              sdo       <= shift_out[15];
              shift_out <= {shift_out[14:0], 1'b0};
            end
            // in full shutdown only a waking write releases the hold
            if (fall_cnt == `ACS_TRACK_EDGE - 1 && (pm_now != `ACS_PM_FULL_SD ||
                (shift_in[`ACS_BIT_WRITE] && new_pm == `ACS_PM_NORMAL))) begin
              track_hold <= 1'b0;
            end
            if (fall_cnt == `ACS_DONE_EDGE - 1) begin
              sdo_oe    <= 1'b0;
              state     <= ST_DONE;
              word_buf  <= {2'h0, conv_chan, pad_result(conv_result, RES_MODE[1:0])};
              word_push <= 1'b1;
            end
          end
        end
        ST_DONE: begin
          if (cs_rise) begin
            state <= ST_IDLE;
            if (shift_in[`ACS_BIT_WRITE]) begin
              ctrl_reg <= shift_in;
              if (new_seq == 2'h3) begin
                seq_active <= 1'b1;
                seq_chan   <= 2'h0;
              end else if (new_seq != 2'h2) begin
                seq_active <= 1'b0;
              end
              range_double <= !shift_in[`ACS_BIT_RANGE];
              if (new_pm == `ACS_PM_NORMAL) begin
                if (pm_now == `ACS_PM_FULL_SD) begin
                  wake_pend <= 1'b1;
                  wake_cnt  <= 7'h00;
                end else begin
                  powered <= 1'b1;
                end
              end else if (new_pm == `ACS_PM_FULL_SD) begin
                powered    <= 1'b0;
                track_hold <= 1'b1;
                wake_pend  <= 1'b0;
              end else if (new_pm == `ACS_PM_AUTO_SD) begin
                powered    <= 1'b0;
              end
            end else if (pm_now == `ACS_PM_AUTO_SD) begin
              powered <= 1'b0;
            end else if (pm_now == `ACS_PM_FULL_SD) begin
              track_hold <= 1'b1;
            end
            // new address picks next direct channel
            if (shift_in[`ACS_BIT_WRITE] && !new_seq[1]) begin
              mux_chan <= new_addr;
            end
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  acs_fifo #(
    .WIDTH (`ACS_WORD_BITS),
    .DEPTH (`ACS_FIFO_DEPTH),
    .AW    (`ACS_FIFO_AW)
  ) u_fifo (
    .core_clk  (core_clk),
    .reset_n   (reset_n),
    .in_valid  (word_push),
    .in_ready  (fifo_in_ready),
    .in_data   (word_buf),
    .out_valid (word_valid),
    .out_ready (word_ready),
    .out_data  (word_data)
  );
endmodule
`default_nettype wire

// >>> test/acs_host.sv
`timescale 1ns/1ns
`default_nettype none
module acs_host (
  input  wire logic core_clk,
  input  wire logic sdo,
  output var  logic cs_n,
  output var  logic sclk,
  output var  logic sdi
);
  initial begin
    cs_n = 1'b1;
    sclk = 1'b1;
    sdi  = 1'b0;
  end
  task automatic wt(input int n);
    repeat (n) @(posedge core_clk);
    #5;
  endtask
  // one frame of n clocks, msb first, sclk still between frames
  task automatic xfer(input logic [15:0] d, input int n, output logic [15:0] q);
    q = 16'h0000;
    wt(1);
    cs_n = 1'b0;
    wt(8);
    for (int i = 0; i < n; i++) begin
      q = {q[14:0], sdo};
      sclk = 1'b0;
      sdi = d[15-i];
      wt(4);
      sclk = 1'b1;
      wt(4);
    end
    cs_n = 1'b1;
    wt(16);
  endtask
endmodule
`default_nettype wire

// >>> test/acs_core_sva.sv
`timescale 1ns/1ns
`default_nettype none
module acs_core_sva (
  input wire logic        core_clk,
  input wire logic        reset_n,
  input wire logic        cs_n,
  input wire logic        sdo_oe,
  input wire logic        track_hold,
  input wire logic        powered,
  input wire logic        range_double,
  input wire logic        conv_start,
  input wire logic        word_valid,
  input wire logic [15:0] word_data,
  input wire logic [11:0] ctrl_reg
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  sequence s_start;
    !cs_n ##1 (track_hold && sdo_oe)[*7];
  endsequence
  sequence s_tail;
    sdo_oe ##[8:30] !sdo_oe;
  endsequence
  property p_start;
    conv_start |-> s_start;
  endproperty
  a_start: assert property (p_start) else $error("start");
  property p_track;
    $fell(track_hold) && !cs_n |-> s_tail;
  endproperty
  a_track: assert property (p_track) else $error("track");
  property p_abort;
    cs_n[*8] |-> !sdo_oe;
  endproperty
  a_abort: assert property (p_abort) else $error("abort");
  property p_ctrl;
    (!cs_n)[*6] |=> $stable(ctrl_reg);
  endproperty
  a_ctrl: assert property (p_ctrl) else $error("ctrl");
  property p_off;
    (ctrl_reg[5:4] == 2'h2 && cs_n)[*5] |-> !powered && track_hold;
  endproperty
  a_off: assert property (p_off) else $error("off");
  property p_auto;
    conv_start && ctrl_reg[5:4] == 2'h1 |-> powered;
  endproperty
  a_auto: assert property (p_auto) else $error("auto wake");
  property p_wake;
    ctrl_reg[5:4] == 2'h3 && $past(ctrl_reg[5:4]) == 2'h2 |-> ##[0:12] powered;
  endproperty
  a_wake: assert property (p_wake) else $error("wake");
  property p_fmt;
    word_valid |-> word_data[15:14] == 2'b00;
  endproperty
  a_fmt: assert property (p_fmt) else $error("fmt");
  property p_range;
    $stable(ctrl_reg[1]) |-> range_double == !ctrl_reg[1];
  endproperty
  a_range: assert property (p_range) else $error("range");
endmodule
`default_nettype wire

// >>> test/tb_adc_channel_sequencer_power_modes.sv
`timescale 1ns/1ns
`default_nettype none
module tb_adc_channel_sequencer_power_modes;
  logic        core_clk = 1'b0;
  logic        reset_n = 1'b0;
  logic        word_ready = 1'b0;
  logic [11:0] conv_result = 12'h000;
  logic        cs_n, sclk, sdi, sdo, sdo_oe, track_hold, powered;
  logic        range_double, conv_start, word_valid, seq_active;
  logic [1:0]  mux_chan;
  logic [15:0] word_data;
  logic [11:0] ctrl_reg;
  logic [15:0] expq[$];
  int          n_errors = 0;
  int          cmp_count = 0;
  int          cyc = 0;
  always #50 core_clk = ~core_clk;
  acs_core #(.RES_MODE(0)) acs_core_inst (.core_clk(core_clk), .reset_n(reset_n),
    .cs_n(cs_n), .sclk(sclk), .sdi(sdi), .sdo(sdo), .sdo_oe(sdo_oe),
    .conv_result(conv_result), .mux_chan(mux_chan), .track_hold(track_hold),
    .powered(powered), .range_double(range_double), .conv_start(conv_start),
    .word_valid(word_valid), .word_ready(word_ready), .word_data(word_data),
    .ctrl_reg(ctrl_reg), .seq_active(seq_active));
  acs_host acs_host_inst (.core_clk(core_clk), .sdo(sdo), .cs_n(cs_n), .sclk(sclk),
    .sdi(sdi));
  task automatic wt(input int n);
    repeat (n) @(posedge core_clk);
    #5;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  function automatic logic [15:0] cw(input logic w, sh, sl, input logic [1:0] a, pm,
                                     input logic r);
    return {w, sh, 2'b00, a, pm, sl, 1'b0, r, 1'b0, 4'h0};
  endfunction
  task automatic run(input logic [15:0] d, input logic [1:0] ch);
    logic [15:0] q;
    conv_result = {ch, 10'h2A5};
    acs_host_inst.xfer(d, 16, q);
    chk(q, {2'b00, ch, ch, 10'h2A5});
    expq.push_back({2'b00, ch, ch, 10'h2A5});
  endtask
  task automatic pop(input int n);
    for (int k = 0; k < n; k++) begin
      for (int i = 0; i < 40 && word_valid !== 1'b1; i++) wt(1);
      chk(word_data, expq.pop_front());
      word_ready = 1'b1;
      wt(1);
      word_ready = 1'b0;
      wt(1);
    end
  endtask
  task automatic t_direct;
    run(cw(1, 0, 0, 2'h2, 2'h3, 0), 2'h0);
    chk(ctrl_reg, cw(1, 0, 0, 2'h2, 2'h3, 0) >> 4);
    run(16'h0000, 2'h2);
    chk(mux_chan, 2'h2);
    chk(range_double, 1'b1);
    run(cw(1, 0, 0, 2'h1, 2'h3, 1), 2'h2);
    chk(range_double, 1'b0);
    run(16'h0000, 2'h1);
    chk(powered, 1'b1);
    pop(4);
    $display("direct done");
  endtask
  task automatic t_seq;
    run(cw(1, 1, 1, 2'h2, 2'h3, 0), 2'h1);
    chk(seq_active, 1'b1);
    for (int i = 0; i < 4; i++) run(16'h0000, 2'(i % 3));
    pop(5);
    run(cw(1, 1, 0, 2'h2, 2'h3, 0), 2'h1);
    run(16'h0000, 2'h2);
    run(cw(1, 0, 0, 2'h3, 2'h3, 0), 2'h0);
    chk(seq_active, 1'b0);
    run(16'h0000, 2'h3);
    pop(4);
    $display("sequence done");
  endtask
  task automatic t_abort;
    logic [15:0] q;
    acs_host_inst.xfer(cw(1, 0, 0, 2'h0, 2'h2, 0), 8, q);
    chk(ctrl_reg, cw(1, 0, 0, 2'h3, 2'h3, 0) >> 4);
    chk(sdo_oe, 1'b0);
    chk(powered, 1'b1);
    $display("abort done");
  endtask
  task automatic t_power;
    run(cw(1, 0, 0, 2'h0, 2'h2, 0), 2'h3);
    chk(powered, 1'b0);
    chk(track_hold, 1'b1);
    run(cw(1, 0, 0, 2'h0, 2'h3, 0), 2'h0);
    chk(powered, 1'b1);
    run(16'h0000, 2'h0);
    run(cw(1, 0, 0, 2'h1, 2'h1, 0), 2'h0);
    chk(powered, 1'b0);
    run(16'h0000, 2'h1);
    chk(powered, 1'b0);
    pop(5);
    $display("power done");
  endtask
  task automatic conclude;
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      conclude;
    end
  end
  initial begin
    wt(12);
    reset_n = 1'b1;
    wt(4);
    t_direct;
    t_seq;
    t_abort;
    t_power;
    conclude;
  end
endmodule
bind acs_core acs_core_sva acs_core_sva_inst (.core_clk(core_clk), .reset_n(reset_n),
  .cs_n(cs_n), .sdo_oe(sdo_oe), .track_hold(track_hold), .powered(powered),
  .range_double(range_double), .conv_start(conv_start), .word_valid(word_valid),
  .word_data(word_data), .ctrl_reg(ctrl_reg));
`default_nettype wire
